//--- rtl/dcc_chan_ctrl.sv
// Channel control, trigger routing and interrupt enable logic.
// Assumes one clock, a byte register port and peripheral/event pins async.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps

module dcc_chan_ctrl
   import dcc_pkg::*;
#(
   parameter bit HAS_EVENT_IN  = 1'b1,  // Channel supports event input
   parameter bit HAS_EVENT_OUT = 1'b1   // Channel supports event output
)
(
   // Clock, reset, enable
   input  wire logic                clk_sys_i,
   input  wire logic                srst_i,
   input  wire logic                ce_i,
   // Register port
   input  wire logic [7:0]          reg_addr_i,
   input  wire logic [7:0]          reg_wdata_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   output logic [7:0]               reg_rdata_o,
   // Peripheral requests and event input (asynchronous)
   input  wire logic [NUM_PERIODIC_TRIGGER-1:0] periph_req_i,
   input  wire logic                event_in_i,
   // Transfer engine status (same clock)
   input  wire logic                block_done_i,
   input  wire logic [1:0]          block_action_i,
   input  wire logic [1:0]          event_output_select_i,
   input  wire logic                beat_done_i,
   input  wire logic                bus_error_i,
   input  wire logic                bad_desc_i,
   // Controls toward the transfer engine
   output logic                     trigger_o,
   output logic [1:0]               trigger_action_o,
   output logic [1:0]               arbitration_level_o,
   output logic                     suspended_o,
   output logic                     cond_trigger_o,
   output logic                     cond_block_o,
   output logic                     skip_suspend_o,
   output logic                     event_out_o,
   output logic                     irq_o
);

   //------------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------------
   logic [31:0]         ctrl_r;          // Second control register
   logic [2:0]          irq_en_r;        // Shared enable bits
   logic [2:0]          irq_flag_r;      // Sticky flags
   logic [2:0]          irq_flag_nxt;    // Next flags
   logic [2:0]          irq_set_evt;     // Hardware set pulses
   dcc_state_t          state_r;         // Run state
   logic                skip_r;          // Skip next block suspend
   logic [NUM_PERIODIC_TRIGGER-1:0] preq_s1_r;       // Request sync stage 1
   logic [NUM_PERIODIC_TRIGGER-1:0] preq_s2_r;       // Request sync stage 2
   logic [NUM_PERIODIC_TRIGGER-1:0] preq_s3_r;       // Request sync stage 3
   logic [NUM_PERIODIC_TRIGGER-1:0] preq_q_r;        // Agreed request level
   logic [NUM_PERIODIC_TRIGGER-1:0] preq_prev_r;     // Previous agreed level
   logic [NUM_PERIODIC_TRIGGER-1:0] preq_rise;       // Request rising edges
   logic                ev_s1_r;         // Event sync stage 1
   logic                ev_s2_r;         // Event sync stage 2
   logic                ev_s3_r;         // Event sync stage 3
   logic                ev_q_r;          // Agreed event level
   logic                ev_pulse;        // Event rising edge
   logic                ev_act;          // Event accepted
   logic [2:0]          ev_code;         // Event action in use
   logic                periph_hit;      // Selected request fired
   logic                wr_cmd;          // Command byte written
   logic [1:0]          cmd_val;         // Written command
   logic                do_suspend;      // Suspend cause this cycle
   logic                do_resume;       // Resume cause this cycle
   logic                blk_suspend;     // Block end wants suspend

   //------------------------------------------------------------------
   // Input synchronisers: three flops, change when stages 2 and 3 agree
   //------------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         preq_s1_r <= '0;
         preq_s2_r <= '0;
         preq_s3_r <= '0;
         ev_s1_r   <= 1'b0;
         ev_s2_r   <= 1'b0;
         ev_s3_r   <= 1'b0;
      end
      else if (ce_i)
      begin
         preq_s1_r <= periph_req_i;
         preq_s2_r <= preq_s1_r;
         preq_s3_r <= preq_s2_r;
         ev_s1_r   <= event_in_i;
         ev_s2_r   <= ev_s1_r;
         ev_s3_r   <= ev_s2_r;
      end
   end

   // Agreed levels, per request line
   generate
      for (genvar g = 0; g < NUM_PERIODIC_TRIGGER; g++)
      begin : g_req
         always_ff @(posedge clk_sys_i)
         begin
            if (srst_i)
            begin
               preq_q_r[g]    <= 1'b0;
               preq_prev_r[g] <= 1'b0;
            end
            else if (ce_i)
            begin
               if (preq_s2_r[g] == preq_s3_r[g])
               begin
                  preq_q_r[g] <= preq_s3_r[g];
               end
               preq_prev_r[g] <= preq_q_r[g];
            end
         end
         assign preq_rise[g] = preq_q_r[g] & ~preq_prev_r[g];
      end
   endgenerate

   // Event agreed level
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         ev_q_r <= 1'b0;
      end
      else if (ce_i && ev_s2_r == ev_s3_r)
      begin
         ev_q_r <= ev_s3_r;
      end
   end

   assign ev_pulse = (ev_s2_r == ev_s3_r) & ev_s3_r & ~ev_q_r;

   //------------------------------------------------------------------
   // Trigger source selection
   //------------------------------------------------------------------
   dcc_periodic_trigger_sel u_periodic_trigger_sel
   (
      .sel_i (ctrl_r[POS_PERIODIC_TRIGGER_SRC +: 5]),
      .req_i (preq_rise),
      .hit_o (periph_hit)
   );

   //------------------------------------------------------------------
   // Decodes of command and event action
   //------------------------------------------------------------------
   assign wr_cmd  = reg_wr_i & (reg_addr_i == OFS_CTRL_SECOND_B3);
   assign cmd_val = reg_wdata_i[1:0];
   // Event controls are dead on a channel without event input
   assign ev_act  = HAS_EVENT_IN & ctrl_r[POS_EVI_EN] & ev_pulse;
   assign ev_code = ev_act ? ctrl_r[POS_EVI_ACT +: 3] : EACT_NONE;
   assign blk_suspend = block_done_i &
                        (block_action_i == BACT_SUSPEND || block_action_i == BACT_BOTH) &
                        ~skip_r;
   assign do_suspend  = (wr_cmd & cmd_val == CMD_SUSPEND)
                      | (ev_code == EACT_SUSPEND)
                      | blk_suspend | bad_desc_i;
   assign do_resume = (wr_cmd & cmd_val == CMD_RESUME)
                    | (ev_code == EACT_RESUME);

   //------------------------------------------------------------------
   // Second control register, command bits self-clear
   //------------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         ctrl_r <= CTRL_SECOND_RESET;
      end
      else if (ce_i)
      begin
         // Command field only ever holds a pending request for one cycle
         ctrl_r[POS_CMD +: 2] <= 2'h0;
         if (reg_wr_i)
         begin
            unique case (reg_addr_i)
               OFS_CTRL_SECOND_B0:
                  ctrl_r[7:0]   <= reg_wdata_i & CTRL_SECOND_MASK[7:0];
               OFS_CTRL_SECOND_B1:
                  ctrl_r[15:8]  <= reg_wdata_i & CTRL_SECOND_MASK[15:8];
               OFS_CTRL_SECOND_B2:
                  ctrl_r[23:16] <= reg_wdata_i & CTRL_SECOND_MASK[23:16];
               OFS_CTRL_SECOND_B3:
                  ctrl_r[31:24] <= reg_wdata_i & CTRL_SECOND_MASK[31:24];
               default:
                  ;
            endcase
         end
      end
   end

   //------------------------------------------------------------------
   // Run state: suspend and resume
   //------------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         state_r <= DCC_IDLE;
      end
      else if (ce_i)
      begin
         unique case (state_r)
            DCC_IDLE:
               if (do_suspend)
               begin
                  state_r <= DCC_SUSPEND;
               end
               else if (trigger_o)
               begin
                  state_r <= DCC_RUN;
               end
            DCC_RUN:
               if (do_suspend)
               begin
                  state_r <= DCC_SUSPEND;
               end
               else if (block_done_i)
               begin
                  state_r <= DCC_IDLE;
               end
            DCC_SUSPEND:
               if (do_resume && !do_suspend)
               begin
                  state_r <= DCC_IDLE;
               end
            default:
               state_r <= DCC_IDLE;
         endcase
      end
   end

   // Skip-next-block-suspend latch, consumed by the next block end
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         skip_r <= 1'b0;
      end
      else if (ce_i)
      begin
         if (ev_code == EACT_SKIP)
         begin
            skip_r <= 1'b1;
         end
         else if (block_done_i)
         begin
            skip_r <= 1'b0;
         end
      end
   end

   //------------------------------------------------------------------
   // Registered outputs toward the transfer engine
   //------------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         trigger_o           <= 1'b0;
         trigger_action_o    <= TACT_BLOCK;
         arbitration_level_o <= 2'h0;
         suspended_o         <= 1'b0;
         cond_trigger_o      <= 1'b0;
         cond_block_o        <= 1'b0;
         skip_suspend_o      <= 1'b0;
         event_out_o         <= 1'b0;
      end
      else if (ce_i)
      begin
         // Trigger: selected peripheral or transfer event
         trigger_o           <= periph_hit | (ev_code == EACT_PERIODIC);
         trigger_action_o    <= ctrl_r[POS_PERIODIC_TRIGGER_ACT +: 2];
         arbitration_level_o <= ctrl_r[POS_ARB_LEVEL +: 2];
         suspended_o         <= (state_r == DCC_SUSPEND);
         cond_trigger_o      <= (ev_code == EACT_COND_XFER);
         cond_block_o        <= (ev_code == EACT_COND_BLOCK);
         skip_suspend_o      <= skip_r;
         // Output event only when enabled and the descriptor asks
         event_out_o         <= HAS_EVENT_OUT & ctrl_r[POS_EVO_EN] &
                                ((event_output_select_i == 2'h1 & block_done_i) |
                                 (event_output_select_i == 2'h3 & beat_done_i));
      end
   end

   //------------------------------------------------------------------
   // Interrupt enables: one shared set, two views
   //------------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         irq_en_r <= IRQ_RESET;
      end
      else if (ce_i && reg_wr_i)
      begin
         if (reg_addr_i == OFS_IRQ_EN_CLEAR)
         begin
            irq_en_r <= irq_en_r & ~reg_wdata_i[2:0];
         end
         else if (reg_addr_i == OFS_IRQ_EN_SET)
         begin
            irq_en_r <= irq_en_r | reg_wdata_i[2:0];
         end
      end
   end

   //------------------------------------------------------------------
   // Sticky flags, write one to clear, hardware set wins
   //------------------------------------------------------------------
   always_comb
   begin
      irq_set_evt              = 3'h0;
      irq_set_evt[BIT_SUSPEND] = do_suspend;
      // No-action and suspend-only block ends leave the done flag alone
      irq_set_evt[BIT_DONE]    = block_done_i &
                                 (block_action_i == BACT_INT || block_action_i == BACT_BOTH);
      irq_set_evt[BIT_FAULT]   = bus_error_i | bad_desc_i;
      irq_flag_nxt = irq_flag_r;
      if (reg_wr_i && reg_addr_i == OFS_IRQ_FLAG)
      begin
         irq_flag_nxt = irq_flag_nxt & ~reg_wdata_i[2:0];
      end
      irq_flag_nxt = irq_flag_nxt | irq_set_evt;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         irq_flag_r <= IRQ_RESET;
         irq_o      <= 1'b0;
      end
      else if (ce_i)
      begin
         irq_flag_r <= irq_flag_nxt;
         irq_o      <= |(irq_flag_nxt & irq_en_r);
      end
   end

   //------------------------------------------------------------------
   // Read data, one cycle after the strobe, zero otherwise
   //------------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         reg_rdata_o <= 8'h00;
      end
      else if (ce_i)
      begin
         reg_rdata_o <= 8'h00;
         if (reg_rd_i)
         begin
            unique case (reg_addr_i)
               OFS_CTRL_SECOND_B0: reg_rdata_o <= ctrl_r[7:0];
               OFS_CTRL_SECOND_B1: reg_rdata_o <= ctrl_r[15:8];
               OFS_CTRL_SECOND_B2: reg_rdata_o <= ctrl_r[23:16];
               OFS_CTRL_SECOND_B3: reg_rdata_o <= ctrl_r[31:24];
               OFS_IRQ_EN_CLEAR:   reg_rdata_o <= {5'h00, irq_en_r};
               OFS_IRQ_EN_SET:     reg_rdata_o <= {5'h00, irq_en_r};
               OFS_IRQ_FLAG:       reg_rdata_o <= {5'h00, irq_flag_r};
               OFS_CH_STATUS:      reg_rdata_o <= {6'h00, state_r};
               default:            reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   chk_clear_view: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && reg_wr_i && reg_addr_i == OFS_IRQ_EN_CLEAR
      |=> (irq_en_r & $past(reg_wdata_i[2:0])) == 3'h0)
      else $error("enable clear write left a bit set");

   chk_set_view: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && reg_wr_i && reg_addr_i == OFS_IRQ_EN_SET
      |=> (irq_en_r & $past(reg_wdata_i[2:0])) == $past(reg_wdata_i[2:0]))
      else $error("enable set write did not enable");

   chk_shared_read: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && reg_rd_i && (reg_addr_i == OFS_IRQ_EN_SET || reg_addr_i == OFS_IRQ_EN_CLEAR)
      |=> reg_rdata_o == {5'h00, $past(irq_en_r)})
      else $error("enable views disagree");

   chk_no_action_done: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && block_done_i && block_action_i == BACT_NONE && !irq_flag_r[BIT_DONE]
      && !(reg_wr_i && reg_addr_i == OFS_IRQ_FLAG) |=> !irq_flag_r[BIT_DONE])
      else $error("done flag set on no-action block");

   chk_suspend_flag: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && wr_cmd && cmd_val == CMD_SUSPEND |=> irq_flag_r[BIT_SUSPEND] ##1 suspended_o)
      else $error("software suspend not flagged");

   chk_fault_flag: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && (bus_error_i || bad_desc_i) |=> irq_flag_r[BIT_FAULT])
      else $error("fault flag not set");

   chk_irq_level: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && $past(ce_i) |-> irq_o == |($past(irq_flag_nxt) & $past(irq_en_r)))
      else $error("interrupt level wrong");

   chk_evin_gate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && !ctrl_r[POS_EVI_EN] && !periph_hit |=> !trigger_o && !cond_block_o)
      else $error("event acted while input disabled");

   chk_evout_gate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ce_i && !ctrl_r[POS_EVO_EN] |=> !event_out_o)
      else $error("event emitted while output disabled");

   chk_resv_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ctrl_r & ~CTRL_SECOND_MASK) == 32'h00000000)
      else $error("reserved control bit set");

endmodule : dcc_chan_ctrl

//--- rtl/dcc_periodic_trigger_sel.sv
// Peripheral trigger source selector.
// Assumes request lines already synchronised to clk_sys_i.
`timescale 1ns/100ps
module dcc_periodic_trigger_sel
   import dcc_pkg::*;
(
   // Selection
   input  wire logic [4:0]          sel_i,
   input  wire logic [NUM_PERIODIC_TRIGGER-1:0] req_i,
   // Result
   output logic                     hit_o
);

   //------------------------------------------------------------------
   // Decode: zero and reserved codes pick nothing
   //------------------------------------------------------------------
   always_comb
   begin
      hit_o = 1'b0;
      if (sel_i == TSRC_NONE)
      begin
         hit_o = 1'b0;
      end
      else if (sel_i >= TSRC_RSV_LO && sel_i <= TSRC_RSV_HI)
      begin
         hit_o = 1'b0;
      end
      else if (sel_i <= TSRC_LAST)
      begin
         hit_o = req_i[sel_i];
      end
   end

endmodule : dcc_periodic_trigger_sel

//--- rtl/dcc_pkg.sv
// Package for the channel control and interrupt-enable block.
// Assumes a byte-wide register view on a plain strobe port, one clock.
package dcc_pkg;

   //------------------------------------------------------------------
   // Register offsets
   //------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_SECOND_B0 = 8'h44;  // Control, bits 7:0
   localparam logic [7:0] OFS_CTRL_SECOND_B1 = 8'h45;  // Control, bits 15:8
   localparam logic [7:0] OFS_CTRL_SECOND_B2 = 8'h46;  // Control, bits 23:16
   localparam logic [7:0] OFS_CTRL_SECOND_B3 = 8'h47;  // Control, bits 31:24
   localparam logic [7:0] OFS_IRQ_EN_CLEAR   = 8'h4C;  // Enable clear view
   localparam logic [7:0] OFS_IRQ_EN_SET     = 8'h4D;  // Enable set view
   localparam logic [7:0] OFS_IRQ_FLAG       = 8'h4E;  // Sticky flags, W1C
   localparam logic [7:0] OFS_CH_STATUS      = 8'h4F;  // Channel state

   //------------------------------------------------------------------
   // Field positions and writable masks
   //------------------------------------------------------------------
   localparam logic [31:0] CTRL_SECOND_MASK  = 32'h03C01F7F; // Writable bits
   localparam logic [31:0] CTRL_SECOND_RESET = 32'h00000000; // Reset value
   localparam int          POS_CMD           = 24;  // Software command
   localparam int          POS_PERIODIC_TRIGGER_ACT      = 22;  // Trigger action
   localparam int          POS_PERIODIC_TRIGGER_SRC      = 8;   // Trigger source
   localparam int          POS_ARB_LEVEL     = 5;   // Arbitration level
   localparam int          POS_EVO_EN        = 4;   // Event output enable
   localparam int          POS_EVI_EN        = 3;   // Event input enable
   localparam int          POS_EVI_ACT       = 0;   // Event input action
   localparam logic [2:0]  IRQ_RESET         = 3'h0; // Enable/flag reset
   localparam int          BIT_SUSPEND       = 2;
   localparam int          BIT_DONE          = 1;
   localparam int          BIT_FAULT         = 0;

   //------------------------------------------------------------------
   // Encodings
   //------------------------------------------------------------------
   localparam logic [1:0] CMD_NONE    = 2'h0;
   localparam logic [1:0] CMD_SUSPEND = 2'h1;
   localparam logic [1:0] CMD_RESUME  = 2'h2;
   localparam logic [1:0] TACT_BLOCK  = 2'h0;
   localparam logic [1:0] TACT_BEAT   = 2'h2;
   localparam logic [1:0] TACT_TRANS  = 2'h3;
   localparam logic [2:0] EACT_NONE       = 3'h0;
   localparam logic [2:0] EACT_PERIODIC   = 3'h1;
   localparam logic [2:0] EACT_COND_XFER  = 3'h2;
   localparam logic [2:0] EACT_COND_BLOCK = 3'h3;
   localparam logic [2:0] EACT_SUSPEND    = 3'h4;
   localparam logic [2:0] EACT_RESUME     = 3'h5;
   localparam logic [2:0] EACT_SKIP       = 3'h6;
   localparam logic [1:0] BACT_NONE    = 2'h0;
   localparam logic [1:0] BACT_INT     = 2'h1;
   localparam logic [1:0] BACT_SUSPEND = 2'h2;
   localparam logic [1:0] BACT_BOTH   = 2'h3;
   localparam logic [4:0] TSRC_NONE   = 5'h00;
   localparam logic [4:0] TSRC_LAST   = 5'h12;
   localparam logic [4:0] TSRC_RSV_LO = 5'h05;
   localparam logic [4:0] TSRC_RSV_HI = 5'h0B;
   localparam int         NUM_PERIODIC_TRIGGER    = 19;  // Request lines 0x00..0x12

   // Channel run state, Gray coded
   typedef enum logic [1:0] {
      DCC_IDLE    = 2'b00,
      DCC_RUN     = 2'b01,
      DCC_SUSPEND = 2'b11
   } dcc_state_t;

endpackage : dcc_pkg

//--- sim/dcc_chan_ctrl_tb.sv
// Bench for the channel control block with a request line model.
// Assumes one 20 MHz clock and a synchronous reset.
`timescale 1ns/100ps
module dcc_chan_ctrl_tb
   import dcc_pkg::*;
;
   logic clk_sys_i = 1'b0, srst_i = 1'b1, wr = 1'b0, rd = 1'b0;
   logic go = 1'b0, ev = 1'b0, bd = 1'b0, be = 1'b0, trg, sus, irq;
   logic bdd = 1'b0, ctg, cbk, skp, evo;
   logic [7:0] a = 8'h00, wd = 8'h00, rdat, v;
   logic [4:0] sel = 5'h00;
   logic [4:0] srcs [7] = '{5'h01, 5'h04, 5'h0C, 5'h12, 5'h05, 5'h0B, 5'h00};
   logic [1:0] ba = 2'h0, eos = 2'h0, tact, arb;
   logic [NUM_PERIODIC_TRIGGER-1:0] req;
   logic evt;
   logic [31:0] rs = 32'h7d125a4c;
   int err_total = 0, num_checks = 0, tn = 0, cn = 0, eo = 0;
   initial forever #25 clk_sys_i = ~clk_sys_i;
   dcc_peer_model pm (.clk_sys_i(clk_sys_i), .go_i(go), .ev_i(ev), .sel_i(sel),
      .req_o(req), .evt_o(evt));
   dcc_chan_ctrl uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1),
      .reg_addr_i(a), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdat), .periph_req_i(req), .event_in_i(evt),
      .block_done_i(bd), .block_action_i(ba), .event_output_select_i(eos),
      .beat_done_i(1'b0), .bus_error_i(be), .bad_desc_i(bdd), .trigger_o(trg),
      .trigger_action_o(tact), .arbitration_level_o(arb), .suspended_o(sus),
      .cond_trigger_o(ctg), .cond_block_o(cbk), .skip_suspend_o(skp), .event_out_o(evo),
      .irq_o(irq));
   // Count trigger, conditional (block in steps of 16) and output event pulses
   always @(posedge clk_sys_i)
   begin
      tn += int'(trg === 1'b1);
      cn += int'(ctg === 1'b1) + 16 * int'(cbk === 1'b1);
      eo += int'(evo === 1'b1);
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic wrt(input logic [7:0] ad, input logic [7:0] d);
      a <= ad; wd <= d; wr <= 1'b1; @(posedge clk_sys_i); wr <= 1'b0; #1;
   endtask : wrt
   task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
      a <= ad; rd <= 1'b1; @(posedge clk_sys_i); rd <= 1'b0; #1 chk(rdat, e);
   endtask : rdc
   // Pulse one request line or the event line, then let it settle
   task automatic fire(input logic [4:0] s, input logic e);
      sel <= s; ev <= e; go <= 1'b1; @(posedge clk_sys_i); go <= 1'b0;
      repeat (12) @(posedge clk_sys_i);
      #1;
   endtask : fire
   // One block end pulse with its action, then two cycles for the outputs
   task automatic blk(input logic [1:0] act);
      ba <= act;
      bd <= 1'b1;
      @(posedge clk_sys_i);
      bd <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask : blk
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   initial
   begin
      repeat (5000) @(posedge clk_sys_i);
      err_total++;
      stop_test();
   end
   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      srst_i <= 1'b0; @(posedge clk_sys_i); #1;
      for (int i = 0; i < 8; i++)
         rdc(8'h44 + 8'(i < 4 ? i : i + 4), 8'h00);
      $display("test reset done");
      for (int k = 0; k < 6; k++)
         for (int i = 0; i < 4; i++)
         begin
            rs = lfsr(rs);
            // Software keeps reserved bits zero; the command byte stays idle
            v = ((k == 0) ? 8'hFF : rs[7:0]) & CTRL_SECOND_MASK[8*i+:8];
            if (i == 3) v = 8'h00;
            wrt(8'h44 + 8'(i), v);
            rdc(8'h44 + 8'(i), v);
            if (i == 0) chk(8'(arb), 8'(v[6:5]));
            if (i == 2) chk(8'(tact), 8'(v[7:6]));
         end
      wrt(8'h44, 8'h00);
      rs = lfsr(rs); v = 8'(rs[2:0]);
      wrt(8'h4D, v); rdc(8'h4C, v);
      wrt(8'h4C, 8'h05); rdc(8'h4D, v & 8'h02);
      wrt(8'h4D, 8'h07); $display("test enables done");
      wrt(8'h47, 8'h01); repeat (3) @(posedge clk_sys_i); #1;
      chk(8'(sus), 8'h01); chk(8'(irq), 8'h01);
      rdc(8'h4E, 8'h04); wrt(8'h47, 8'h02); wrt(8'h4E, 8'h04);
      repeat (3) @(posedge clk_sys_i); #1;
      chk(8'(sus), 8'h00); chk(8'(irq), 8'h00);
      foreach (srcs[i])
      begin
         v = 8'(srcs[i]);
         wrt(8'h45, v); tn = 0; fire(v[4:0], 1'b0);
         chk(8'(tn), i < 4 ? 8'h01 : 8'h00);
      end
      ba <= BACT_NONE; bd <= 1'b1; @(posedge clk_sys_i); bd <= 1'b0; #1;
      rdc(8'h4E, 8'h00);
      ba <= BACT_INT; bd <= 1'b1; be <= 1'b1; @(posedge clk_sys_i);
      bd <= 1'b0; be <= 1'b0; #1 rdc(8'h4E, 8'h03);
      wrt(8'h4E, 8'h03); $display("test flags done");
      wrt(8'h44, 8'h0C); fire(5'h00, 1'b1); chk(8'(sus), 8'h01);
      wrt(8'h44, 8'h05); fire(5'h00, 1'b1); chk(8'(sus), 8'h01);
      wrt(8'h44, 8'h0D); fire(5'h00, 1'b1); chk(8'(sus), 8'h00);
      wrt(8'h44, 8'h09); tn = 0; fire(5'h00, 1'b1); chk(8'(tn), 8'h01);
      wrt(8'h44, 8'h0A); cn = 0; fire(5'h00, 1'b1); chk(8'(cn), 8'h01);
      wrt(8'h44, 8'h0B); cn = 0; fire(5'h00, 1'b1); chk(8'(cn), 8'h10);
      wrt(8'h44, 8'h0E); wrt(8'h4E, 8'h07); fire(5'h00, 1'b1);
      chk(8'(skp), 8'h01);
      blk(BACT_SUSPEND); chk(8'(sus), 8'h00); chk(8'(skp), 8'h00);
      rdc(8'h4E, 8'h00);
      blk(BACT_SUSPEND); chk(8'(sus), 8'h01); rdc(8'h4E, 8'h04);
      $display("test events done");
      wrt(8'h47, 8'h02); wrt(8'h4E, 8'h07);
      bdd <= 1'b1; @(posedge clk_sys_i); bdd <= 1'b0;
      #1 rdc(8'h4E, 8'h05);
      chk(8'(sus), 8'h01);
      wrt(8'h44, 8'h10); eos <= 2'h1; eo = 0; blk(BACT_NONE);
      chk(8'(eo), 8'h01);
      wrt(8'h44, 8'h00); eo = 0; blk(BACT_NONE);
      chk(8'(eo), 8'h00);
      $display("test options done");
      stop_test();
   end
endmodule : dcc_chan_ctrl_tb

//--- sim/dcc_peer_model.sv
// Model of the peripheral request lines and the event input channel.
// Assumes pulse commands from the bench on clk_sys_i.
`timescale 1ns/100ps
module dcc_peer_model
   import dcc_pkg::*;
(
   // Command from the bench
   input  wire logic                clk_sys_i,
   input  wire logic                go_i,
   input  wire logic                ev_i,
   input  wire logic [4:0]          sel_i,
   // Lines toward the block
   output logic [NUM_PERIODIC_TRIGGER-1:0]      req_o,
   output logic                     evt_o
);
   logic [2:0] hold_r = 3'h0;  // Cycles left on the pulse
   // A line stands four cycles so the synchronisers see it
   always_ff @(posedge clk_sys_i)
   begin
      if (go_i)
         hold_r <= 3'h4;
      else if (hold_r != 3'h0)
         hold_r <= hold_r - 3'h1;
   end
   assign req_o = (hold_r != 3'h0 && !ev_i) ? NUM_PERIODIC_TRIGGER'(1) << sel_i : '0;
   assign evt_o = (hold_r != 3'h0) && ev_i;
endmodule : dcc_peer_model
